// >>> design/emc_params.svh
// Purpose: Constants for the event mode counter
// Assumes: 16-bit counter, sys_clk at 20 MHz
// Notes: Register map is a plain address/strobe port
// Operation
// - The counter advances only on external events from the pin or the preceding timer's overflow.
// - The count direction follows the count direction bit.
// - When enabled, the pulse output pin inverts on each overflow or underflow.
// - Source and edge fields select rising, falling or both edges of pin or overflow input.
// - On underflow the counter loads the reload value if reload is enabled, else wraps to FFFFh.
// - On overflow the counter loads the reload value if reload is enabled, else wraps to 0000h.
// - Timer and filter clocks accept every programmable frequency selection.
// - Counting starts when enable is set and stops when it is cleared.
// - Re-enabling resumes from the current value unless a reset event occurred.
// - After a reset event the counter starts from reload when down, 0000h when up.
// - An interrupt request is raised on every overflow or underflow; the code raises irq only when the matching interrupt enable bit is set.
`ifndef EMC_PARAMS_SVH
`define EMC_PARAMS_SVH
`define EMC_ADDR_CTRL 4'h0
`define EMC_ADDR_RELOAD 4'h1
`define EMC_ADDR_COUNT 4'h2
`define EMC_ADDR_STATUS 4'h3
`define EMC_ADDR_CLEAR 4'h4
`define EMC_ADDR_IEN 4'h5
`define EMC_ADDR_CLKSEL 4'h6
`define EMC_B_ENABLE 0
`define EMC_B_UP 1
`define EMC_B_RELOAD_ENABLE 2
`define EMC_B_POUT 3
`define EMC_B_SRC 4
`define EMC_B_EDGE_LO 5
`define EMC_B_EDGE_HI 6
`define EMC_B_RESET 7
`define EMC_ST_OVF 0
`define EMC_ST_UNF 1
`define EMC_CNT_ZERO 16'h0000
`define EMC_CNT_MAX 16'hFFFF
`define EMC_RELOAD_RST 16'hFFFF
`define EMC_FILT_TAPS 3
`endif

// >>> design/emc_pkg.sv
// Purpose: Types for the event mode counter
// Assumes: Constants live in emc_params.svh
// Notes: Edge select encoding 1 rise, 2 fall, 3 both, 0 none
package emc_pkg;
  typedef enum logic [1:0] {
    EMC_EDGE_NONE,
    EMC_EDGE_RISE,
    EMC_EDGE_FALL,
    EMC_EDGE_BOTH
  } emc_edge_e;
  typedef struct packed {
    logic pin_src;
    emc_edge_e edge_sel;
  } emc_trig_s;
  typedef struct packed {
    logic ovf;
    logic unf;
  } emc_wrap_s;
endpackage : emc_pkg

// >>> design/emc_prescaler.sv
// Purpose: Divides sys_clk into one-cycle enable pulses
// Assumes: Select picks divide by 2**sel
// Notes: Used for both timer clock and filter clock
`timescale 1ns/100ps
module emc_prescaler #(
  parameter int SEL_W = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [SEL_W-1:0] div_sel,
  output logic tick
);
  logic [15:0] div_q;
  logic [15:0] mask;

  // Free running divider
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // Tick when low bits all zero; sel 0 ticks every cycle
  assign mask = 16'((32'h1 << div_sel) - 32'h1);
  assign tick = (div_q & mask) == 16'h0000;
endmodule : emc_prescaler

// >>> design/emc_filter.sv
// Purpose: Synchronises and filters the event pin
// Assumes: Filter samples on filter tick
// Notes: Output changes only when TAPS samples agree
`timescale 1ns/100ps
`include "emc_params.svh"
module emc_filter #(
  parameter int TAPS = `EMC_FILT_TAPS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic filt_tick,
  input wire logic pin_in,
  output logic pin_clean
);
  logic sync1_q;
  logic sync2_q;
  logic [TAPS-1:0] hist_q;

  // Two-stage synchroniser
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Sample history on filter clock, accept stable level
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hist_q <= '0;
      pin_clean <= 1'b0;
    end else if (filt_tick) begin
      hist_q <= {hist_q[TAPS-2:0], sync2_q};
      if (&hist_q) begin
        pin_clean <= 1'b1;
      end else if (~|hist_q) begin
        pin_clean <= 1'b0;
      end
    end
  end
endmodule : emc_filter

// >>> design/emc_counter.sv
// Purpose: 16-bit event mode counter with register port and interrupt
// Assumes: One clock; timer and filter rates are enable pulses
// Notes: Reset event is the write-one reset bit of control
//   Register map, one 32-bit word per index:
//   0 control
//     bit 0    enable; counting stops while clear
//     bit 1    direction, 1 counts up and 0 counts down
//     bit 2    reload enable for wrap handling
//     bit 3    pulse output enable
//     bit 4    event source, 1 the pin and 0 the preceding overflow; reads back at bit 6
//     bits 6:5 edge select, 1 rise, 2 fall, 3 both, 0 none; reads back at bits 5:4
//     bit 7    reset event, write one, never stored
//   1 reload value, low 16 bits
//   2 count value, read only
//   3 status, read only, bit 0 overflow, bit 1 underflow
//   4 status clear, write only, write one to clear
//   5 interrupt enable, same layout as status
//   6 clock select, bits 3:0 timer, bits 11:8 filter
//     each field divides sys_clk by two to the power of its value
//   Hazards:
//     a wrap in the same cycle as a clear keeps its status bit
//     several edges between two timer ticks count as one step
//     the pin path adds two sync flops and the filter latency
//     reads of unmapped indices return zero
//   Timing:
//     pin edge reaches the counter after sync, filter and detect flops
//     overflow source edge reaches it after two flops
//     the count changes on the timer tick after the edge is seen
//     irq follows a status bit set by one cycle
//     pulse output toggles in the cycle after the wrap step
//   Limits:
//     edges closer than one timer tick merge into one step
//     the filter ignores pulses shorter than three filter ticks
//     a reset event also drops any pending event
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "emc_params.svh"
module emc_counter #(
  parameter int CNT_W = 16,
  parameter int SEL_W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Event link and outputs
  input wire logic event_input_pin,
  input wire logic prev_overflow,
  output logic pulse_output_pin,
  output logic irq
);
  // Control register fields
  logic enable_q;
  logic count_direction_bit_q;
  logic reload_enable_q;
  logic pulse_en_q;
  emc_pkg::emc_trig_s trig_q;

  // Reload, count and clock selections
  logic [CNT_W-1:0] reload_q;
  logic [CNT_W-1:0] count_q;
  logic [SEL_W-1:0] tclk_sel_q;
  logic [SEL_W-1:0] fclk_sel_q;

  // Status and interrupt enables
  emc_pkg::emc_wrap_s status_q;
  emc_pkg::emc_wrap_s ien_q;

  // Divider ticks and the filtered pin
  logic timer_tick;
  logic filt_tick;
  logic pin_clean;

  // Edge detection and pending event
  logic src_q;
  logic src_prev_q;
  logic ev_pend_q;
  logic edge_hit;
  logic rise;
  logic fall;

  // Count stepping, wrap and read word
  logic step;
  logic wr_ctrl;
  logic reset_ev;
  emc_pkg::emc_wrap_s wrap;
  logic [CNT_W-1:0] count_d;
  logic at_max;
  logic at_zero;
  logic [31:0] rd_word_d;

  // Timer clock enable
  emc_prescaler #(.SEL_W(SEL_W)) u_tclk (
    .sys_clk(sys_clk),
    .reset(reset),
    .div_sel(tclk_sel_q),
    .tick(timer_tick)
  );

  // Filter clock enable
  emc_prescaler #(.SEL_W(SEL_W)) u_fclk (
    .sys_clk(sys_clk),
    .reset(reset),
    .div_sel(fclk_sel_q),
    .tick(filt_tick)
  );

  // Pin synchroniser and filter
  emc_filter u_filt (
    .sys_clk(sys_clk),
    .reset(reset),
    .filt_tick(filt_tick),
    .pin_in(event_input_pin),
    .pin_clean(pin_clean)
  );

  // Control write and its reset event strobe
  assign wr_ctrl = reg_wr && (reg_addr == `EMC_ADDR_CTRL);
  assign reset_ev = wr_ctrl && reg_wdata[`EMC_B_RESET];

  // Control register fields
  // Reset event bit is a strobe and is never stored
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      enable_q <= 1'b0;
      count_direction_bit_q <= 1'b0;
      reload_enable_q <= 1'b0;
      pulse_en_q <= 1'b0;
      trig_q <= '0;
    end else if (wr_ctrl) begin
      enable_q <= reg_wdata[`EMC_B_ENABLE];
      count_direction_bit_q <= reg_wdata[`EMC_B_UP];
      reload_enable_q <= reg_wdata[`EMC_B_RELOAD_ENABLE];
      pulse_en_q <= reg_wdata[`EMC_B_POUT];
      trig_q.pin_src <= reg_wdata[`EMC_B_SRC];
      trig_q.edge_sel <= emc_pkg::emc_edge_e'(
        reg_wdata[`EMC_B_EDGE_HI:`EMC_B_EDGE_LO]);
    end
  end

  // Reload value and clock selections
  // New reload reaches the count only on a reset event or a wrap
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reload_q <= `EMC_RELOAD_RST;
      tclk_sel_q <= '0;
      fclk_sel_q <= '0;
    end else if (reg_wr) begin
      if (reg_addr == `EMC_ADDR_RELOAD) begin
        reload_q <= reg_wdata[CNT_W-1:0];
      end
      if (reg_addr == `EMC_ADDR_CLKSEL) begin
        tclk_sel_q <= reg_wdata[SEL_W-1:0];
        fclk_sel_q <= reg_wdata[SEL_W+7:8];
      end
    end
  end

  // Event source and edge detection
  // Both sources idle low, so the detect flops reset low
  // and no false edge follows reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      src_q <= 1'b0;
      src_prev_q <= 1'b0;
    end else begin
      src_q <= trig_q.pin_src ? pin_clean : prev_overflow;
      src_prev_q <= src_q;
    end
  end

  assign rise = src_q && !src_prev_q;
  assign fall = !src_q && src_prev_q;

  // Edge qualification by selected edge type
  // Edge code none blocks every event
  always_comb begin
    case (trig_q.edge_sel)
      emc_pkg::EMC_EDGE_RISE: begin
        edge_hit = rise;
      end
      emc_pkg::EMC_EDGE_FALL: begin
        edge_hit = fall;
      end
      emc_pkg::EMC_EDGE_BOTH: begin
        edge_hit = rise || fall;
      end
      default: begin
        edge_hit = 1'b0;
      end
    endcase
  end

  // Hold an event until the next timer clock tick
  // A slow timer clock would otherwise miss a one-cycle edge
  // Edges that meet while one is pending merge into one step
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ev_pend_q <= 1'b0;
    end else if (!enable_q || reset_ev) begin
      ev_pend_q <= 1'b0;
    end else if (edge_hit) begin
      ev_pend_q <= 1'b1;
    end else if (timer_tick) begin
      ev_pend_q <= 1'b0;
    end
  end

  assign step = enable_q && ev_pend_q && timer_tick;

  // Wrap points of the counter in either direction
  assign at_max = (count_q == `EMC_CNT_MAX);
  assign at_zero = (count_q == `EMC_CNT_ZERO);

  // Next count value with wrap handling
  // A reset event wins over a step in the same cycle
  // Its direction comes from the same write, not the old field
  always_comb begin
    wrap = '0;
    count_d = count_q;
    if (reset_ev) begin
      count_d = reg_wdata[`EMC_B_UP] ? `EMC_CNT_ZERO : reload_q;
    end else if (step) begin
      if (count_direction_bit_q) begin
        if (at_max) begin
          wrap.ovf = 1'b1;
          count_d = reload_enable_q ? reload_q : `EMC_CNT_ZERO;
        end else begin
          count_d = count_q + 16'h0001;
        end
      end else begin
        if (at_zero) begin
          wrap.unf = 1'b1;
          count_d = reload_enable_q ? reload_q : `EMC_CNT_MAX;
        end else begin
          count_d = count_q - 16'h0001;
        end
      end
    end
  end

  // Counter holds while disabled unless a reset event loads it
  // Re-enabling resumes from the held value
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_q <= `EMC_CNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  // Pulse output toggles on wrap
  // Output holds its level while the pulse function is off
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pulse_output_pin <= 1'b0;
    end else if (pulse_en_q && (wrap.ovf || wrap.unf)) begin
      pulse_output_pin <= !pulse_output_pin;
    end
  end

  // Sticky status; set wins over clear
  // A wrap in the clear cycle must not be lost
  // Bits stay set until software clears them
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      status_q <= '0;
    end else begin
      if (reg_wr && reg_addr == `EMC_ADDR_CLEAR) begin
        status_q.ovf <= (status_q.ovf && !reg_wdata[`EMC_ST_OVF]) ||
          wrap.ovf;
        status_q.unf <= (status_q.unf && !reg_wdata[`EMC_ST_UNF]) ||
          wrap.unf;
      end else begin
        status_q <= status_q | wrap;
      end
    end
  end

  // Interrupt enables
  // Same layout as status
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ien_q <= '0;
    end else if (reg_wr && reg_addr == `EMC_ADDR_IEN) begin
      ien_q.ovf <= reg_wdata[`EMC_ST_OVF];
      ien_q.unf <= reg_wdata[`EMC_ST_UNF];
    end
  end

  // Level interrupt from a flip-flop
  // Lags status and enables by one cycle
  // Drops once every enabled bit is clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & ien_q);
    end
  end

  // Read word chosen from the address; unmapped indices give zero
  always_comb begin
    rd_word_d = 32'h00000000;
    case (reg_addr)
      `EMC_ADDR_CTRL: begin
        rd_word_d = {25'h0, trig_q, pulse_en_q, reload_enable_q,
          count_direction_bit_q, enable_q};
      end
      `EMC_ADDR_RELOAD: begin
        rd_word_d = {16'h0000, reload_q};
      end
      `EMC_ADDR_COUNT: begin
        rd_word_d = {16'h0000, count_q};
      end
      `EMC_ADDR_STATUS: begin
        rd_word_d = {30'h0, status_q.unf, status_q.ovf};
      end
      `EMC_ADDR_IEN: begin
        rd_word_d = {30'h0, ien_q.unf, ien_q.ovf};
      end
      `EMC_ADDR_CLKSEL: begin
        rd_word_d = {20'h0, fclk_sel_q, 4'h0, tclk_sel_q};
      end
      default: begin
        rd_word_d = 32'h00000000;
      end
    endcase
  end

  // Read data one cycle after the read strobe, zero otherwise
  // Zero outside the answer cycle keeps stale data off the bus
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rd_word_d;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule : emc_counter

// >>> sim/emc_chk_sva.sv
// Purpose: Port checks for emc_counter
// Assumes: Register map of emc_params.svh
// Notes: Shadows track the written fields
`timescale 1ns/100ps
`include "emc_params.svh"
module emc_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic pulse_output_pin,
  input wire logic irq
);
  logic en_q;
  logic [15:0] rl_q;
  logic [1:0] ie_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Shadow of written enable, reload and irq enable
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      en_q <= 1'b0;
      rl_q <= `EMC_RELOAD_RST;
      ie_q <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == 4'h0) en_q <= reg_wdata[0];
      if (reg_addr == 4'h1) rl_q <= reg_wdata[15:0];
      if (reg_addr == 4'h5) ie_q <= reg_wdata[1:0];
    end
  end
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_ctl(v);
    reg_wr && reg_addr == 4'h0 && reg_wdata[7:0] == v;
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data set with no read");
  a_reset_quiet: assert property ($fell(reset) |->
    !irq && !pulse_output_pin) else $error("outputs set after reset");
  a_reload_back: assert property (
    reg_wr && reg_addr == 4'h1 ##1 s_rd(4'h1)
    |=> reg_rdata == {16'h0, rl_q}) else $error("reload readback");
  a_rst_up_zero: assert property (
    s_ctl(8'h82) ##1 s_rd(4'h2) |=> reg_rdata == 32'h0)
    else $error("reset event up not zero");
  a_rst_dn_reload: assert property (
    s_ctl(8'h80) ##1 s_rd(4'h2) |=> reg_rdata == {16'h0, rl_q})
    else $error("reset event down not reload");
  a_hold_disabled: assert property (
    s_rd(4'h2) ##0 !en_q ##1 s_rd(4'h2) |=> reg_rdata == $past(reg_rdata))
    else $error("count moved while disabled");
  a_status_sticky: assert property (
    s_rd(4'h3) ##1 s_rd(4'h3) |=> ($past(reg_rdata) & ~reg_rdata) == 32'h0)
    else $error("status bit dropped");
  a_irq_masked: assert property (
    irq |-> (ie_q | $past(ie_q)) != 2'h0) else $error("irq while masked");
endmodule : emc_chk
bind emc_counter emc_chk u_chk (.sys_clk, .reset, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .pulse_output_pin, .irq);

// >>> sim/emc_evsrc.sv
// Purpose: Model of the two event sources
// Assumes: Lines idle low between pulses
// Notes: Hold gives prompt or slow events
`timescale 1ns/100ps
module emc_evsrc (
  input wire logic sys_clk,
  output logic event_input_pin = 1'b0,
  output logic prev_overflow = 1'b0
);
  // One pulse, high then low, each held for hold cycles
  task automatic pulse(input bit pin, input int hold);
    if (pin) event_input_pin <= 1'b1;
    else prev_overflow <= 1'b1;
    repeat (hold) @(posedge sys_clk);
    if (pin) event_input_pin <= 1'b0;
    else prev_overflow <= 1'b0;
    repeat (hold) @(posedge sys_clk);
  endtask : pulse
endmodule : emc_evsrc

// >>> sim/emc_counter_bench.sv
// Purpose: Register level test of emc_counter
// Assumes: Events come from emc_evsrc
// Notes: Divider test uses slow pulses
`timescale 1ns/100ps
module emc_counter_bench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic event_input_pin;
  logic prev_overflow;
  logic pulse_output_pin;
  logic irq;
  int n_mismatch = 0;
  int compares = 0;
  // Clock at 20 MHz
  always #25 sys_clk = ~sys_clk;
  emc_counter u_dut (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .event_input_pin, .prev_overflow,
    .pulse_output_pin, .irq);
  emc_evsrc u_src (.sys_clk, .event_input_pin, .prev_overflow);
  task automatic finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  // Read, then compare in the cycle after
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge sys_clk);
    #1 chk(reg_rdata, e);
  endtask : rc
  task automatic ev(input bit pin, input int n, input int hold);
    cyc(1);
    repeat (n) u_src.pulse(pin, hold);
    cyc(12);
  endtask : ev
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rc(4'h2, 32'h0);
    rc(4'h1, 32'hFFFF);
    rc(4'h3, 32'h0);
    rc(4'h7, 32'h0);
    chk(pulse_output_pin, 1'b0);
    for (int s = 0; s < 2; s++) begin
      for (int e = 1; e < 4; e++) begin
        wr(4'h0, 32'h83 | (s << 4) | (e << 5));
        ev(s[0], 2, 8);
        rc(4'h2, (e == 3) ? 32'h4 : 32'h2);
      end
    end
    wr(4'h0, 32'h31);
    ev(1'b1, 1, 8);
    rc(4'h2, 32'h3);
    wr(4'h0, 32'h30);
    ev(1'b1, 2, 8);
    rc(4'h2, 32'h3);
    rc(4'h2, 32'h3);
    wr(4'h0, 32'h31);
    ev(1'b1, 1, 8);
    rc(4'h2, 32'h2);
    wr(4'h0, 32'h82);
    rc(4'h2, 32'h0);
    wr(4'h1, 32'h1);
    rc(4'h1, 32'h1);
    wr(4'h0, 32'h80);
    rc(4'h2, 32'h1);
    wr(4'h5, 32'h3);
    wr(4'h0, 32'h39);
    ev(1'b1, 2, 8);
    rc(4'h2, 32'hFFFF);
    rc(4'h3, 32'h2);
    rc(4'h3, 32'h2);
    chk(irq, 1'b1);
    chk(pulse_output_pin, 1'b1);
    wr(4'h0, 32'h3B);
    ev(1'b1, 1, 8);
    rc(4'h2, 32'h0);
    rc(4'h3, 32'h3);
    chk(pulse_output_pin, 1'b0);
    wr(4'h5, 32'h0);
    cyc(3);
    chk(irq, 1'b0);
    wr(4'h5, 32'h1);
    wr(4'h4, 32'h1);
    cyc(3);
    chk(irq, 1'b0);
    rc(4'h3, 32'h2);
    wr(4'h4, 32'h2);
    rc(4'h3, 32'h0);
    wr(4'h1, 32'hFFFE);
    wr(4'h0, 32'hBD);
    wr(4'h0, 32'h3F);
    ev(1'b1, 2, 8);
    rc(4'h2, 32'hFFFE);
    wr(4'h1, 32'h1);
    wr(4'h0, 32'hBD);
    ev(1'b1, 2, 8);
    rc(4'h2, 32'h1);
    wr(4'h6, 32'h202);
    wr(4'h0, 32'hB3);
    ev(1'b1, 2, 20);
    rc(4'h2, 32'h2);
    finish_test();
  end
  // Watchdog well past the expected run
  initial begin
    #2000000;
    n_mismatch++;
    finish_test();
  end
endmodule : emc_counter_bench
